// file: hw/smbrp_device.sv
// Register port slave: bit engine, pointer and register file
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`include "smbrp_defines.svh"
module smbrp_device
  import smbrp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `SMBRP_TIMEOUT_CYC
) (
  input  wire logic   clk,
  input  wire logic   rst,
  smbrp_if.device     bus,
  output smbrp_pin_role_type pin_role,
  output logic [7:0]  pointer,
  output logic        timeout_disable
);
  typedef enum logic [2:0] {
    SMBRP_IDLE, SMBRP_ADDR, SMBRP_WR, SMBRP_RD, SMBRP_IGNORE
  } smbrp_state_type;

  // ************************************************
  // Line sampling and condition detection
  // ************************************************
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  smbrp_sync u_scl (.clk(clk), .rst(rst), .din(bus.scl), .dout(scl_s));
  smbrp_sync u_sda (.clk(clk), .rst(rst), .din(bus.sda), .dout(sda_s));

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ************************************************
  // Byte engine state
  // ************************************************
  smbrp_state_type state_q;
  smbrp_state_type state_d;
  logic [3:0]  bit_q;
  logic [7:0]  shift_q;
  logic [1:0]  wcnt_q;
  logic [7:0]  ptr_q;
  logic [7:0]  tx_q;
  logic        sda_o_q;
  logic        sda_oe_q;
  logic        rdp_q;
  logic        hit_q;
  logic [31:0] idle_q;
  logic [7:0]  regs_q [256];

  wire byte_done = scl_rise & (bit_q == 4'd7);
  wire [7:0] rx_byte = {shift_q[6:0], sda_s};
  wire addr_hit  = rx_byte[7:1] == `SMBRP_DEV_ADDR;
  wire ack_slot  = bit_q == 4'd8;
  wire bus_timeout_disable     = regs_q[`SMBRP_CFG1_OFFSET][`SMBRP_BUS_TIMEOUT_DISABLE_BIT];
  wire timed_out = ~bus_timeout_disable & (idle_q >= TIMEOUT_CYC) & (state_q != SMBRP_IDLE);
  wire wr_ptr    = (state_q == SMBRP_WR) & byte_done & (wcnt_q == 2'd0);
  wire wr_data   = (state_q == SMBRP_WR) & byte_done & (wcnt_q == 2'd1);

  // Next state; a start restarts decoding from any state
  always_comb begin
    state_d = state_q;
    case (state_q)
      SMBRP_IDLE:   state_d = SMBRP_IDLE;
      SMBRP_ADDR: begin
        if (byte_done) begin
          if (!addr_hit) state_d = SMBRP_IGNORE;
          else if (rx_byte[0]) state_d = SMBRP_RD;
          else state_d = SMBRP_WR;
        end
      end
      SMBRP_WR:     state_d = (byte_done && wcnt_q == 2'd2) ? SMBRP_IGNORE : SMBRP_WR;
      SMBRP_RD:     state_d = (scl_rise && ack_slot && sda_s) ? SMBRP_IGNORE : SMBRP_RD;
      SMBRP_IGNORE: state_d = SMBRP_IGNORE;
      default:      state_d = SMBRP_IDLE;
    endcase
    if (start_c) state_d = SMBRP_ADDR;
    else if (stop_c || timed_out) state_d = SMBRP_IDLE;
  end

  // State, bit counter and shifter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SMBRP_IDLE;
      bit_q   <= 4'd0;
      shift_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (start_c) bit_q <= 4'd0;
      else if (scl_rise) bit_q <= ack_slot ? 4'd0 : bit_q + 4'd1;
      if (scl_rise) shift_q <= rx_byte;
    end
  end

  // Write byte counter, reset per transaction
  always_ff @(posedge clk) begin
    if (rst) begin
      wcnt_q <= 2'd0;
    end else if (start_c) begin
      wcnt_q <= 2'd0;
    end else if ((state_q == SMBRP_WR) && byte_done) begin
      wcnt_q <= wcnt_q + 2'd1;
    end
  end

  // ************************************************
  // Pointer and register file
  // ************************************************
  // Pointer survives stops and restarts
  always_ff @(posedge clk) begin
    if (rst) ptr_q <= `SMBRP_REG_RESET;
    else if (wr_ptr) ptr_q <= rx_byte;
  end

  // One flip-flop byte per register address
  for (genvar i = 0; i < 256; i++) begin : g_reg
    always_ff @(posedge clk) begin
      if (rst) regs_q[i] <= `SMBRP_REG_RESET;
      else if (wr_data && ptr_q == 8'(i)) regs_q[i] <= rx_byte;
    end
  end

  // ************************************************
  // Data line driver and idle timer
  // ************************************************
  // The state has already moved on when the address acknowledge is due, so a hit is remembered
  wire addr_take = (state_q == SMBRP_ADDR) & byte_done & addr_hit;
  wire ack_now   = ack_slot & (hit_q | ((state_q == SMBRP_WR) & (wcnt_q != 2'd0)));
  wire rd_bit    = (state_q == SMBRP_RD) & rdp_q & ~ack_slot;
  wire rd_load   = (state_q == SMBRP_RD) & hit_q;
  // Changes on falling clock, and releases at once on start, stop or timeout; drives low or releases
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_o_q  <= 1'b0;
      sda_oe_q <= 1'b0;
      tx_q     <= 8'h00;
      rdp_q    <= 1'b0;
      hit_q    <= 1'b0;
    end else if (start_c || stop_c || timed_out) begin
      sda_oe_q <= 1'b0;
      rdp_q    <= 1'b0;
      hit_q    <= 1'b0;
    end else if (addr_take) begin
      hit_q <= 1'b1;
    end else if (scl_fall) begin
      hit_q <= 1'b0;
      if (rd_bit) begin
        sda_oe_q <= ~tx_q[7];
        tx_q     <= {tx_q[6:0], 1'b0};
      end else begin
        sda_oe_q <= ack_now;
      end
      if (rd_load) begin
        tx_q  <= regs_q[ptr_q];
        rdp_q <= 1'b1;
      end
    end
  end

  // Counts clocks without a clock edge, start or stop
  always_ff @(posedge clk) begin
    if (rst) idle_q <= 32'd0;
    else if (scl_rise || scl_fall || start_c || stop_c) idle_q <= 32'd0;
    else if (idle_q < TIMEOUT_CYC) idle_q <= idle_q + 32'd1;
  end

  // ************************************************
  // Outputs
  // ************************************************
  logic [1:0] role_q;
  logic       bus_timeout_disable_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      role_q  <= 2'b00;
      bus_timeout_disable_q <= 1'b0;
    end else begin
      role_q  <= regs_q[`SMBRP_PINFN_OFFSET][1:0];
      bus_timeout_disable_q <= bus_timeout_disable;
    end
  end
  assign pin_role        = smbrp_pin_role_type'(role_q);
  assign pointer         = ptr_q;
  assign timeout_disable = bus_timeout_disable_q;
  assign bus.sda_o_s     = sda_o_q;
  assign bus.sda_oe_s    = sda_oe_q;
endmodule : smbrp_device

// file: hw/smbrp_defines.svh
// Constants shared by the register port device and its bus master
`ifndef SMBRP_DEFINES_SVH
`define SMBRP_DEFINES_SVH
`define SMBRP_DEV_ADDR        7'h2e
`define SMBRP_PINFN_OFFSET    8'h7d
`define SMBRP_CFG1_OFFSET     8'h40
`define SMBRP_BUS_TIMEOUT_DISABLE_BIT       6
`define SMBRP_REG_RESET       8'h00
`define SMBRP_CLK_NS          8
`define SMBRP_TIMEOUT_MS      35
`define SMBRP_TIMEOUT_CYC     ((`SMBRP_TIMEOUT_MS * 1000000) / `SMBRP_CLK_NS)
`define SMBRP_HALF_DIV        8'd31
`define SMBRP_HOST_CMD        4'h0
`define SMBRP_HOST_STATUS     4'h1
`define SMBRP_HOST_PTR        4'h2
`define SMBRP_HOST_WDATA      4'h3
`define SMBRP_HOST_RDATA      4'h4
`define SMBRP_HOST_START      0
`define SMBRP_HOST_READ       1
`define SMBRP_HOST_TWO        2
`endif

// file: hw/smbrp_pkg.sv
// Types shared by the register port device and its bus master
package smbrp_pkg;
  typedef enum logic [1:0] {
    SMBRP_PIN_FAN_TACH_INPUT_FOUR,
    SMBRP_PIN_THERMAL_PIN_FUNCTION,
    SMBRP_PIN_ALERT_OUT,
    SMBRP_PIN_GPIO
  } smbrp_pin_role_type;
endpackage : smbrp_pkg

// file: hw/smbrp_if.sv
// Two-wire bus carrier between master and register port device
`timescale 1ns/100ps
interface smbrp_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  wire  scl = ~(scl_oe_m & ~scl_o_m);
  wire  sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));
  modport master (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m, input scl, input sda);
  modport device (output sda_o_s, output sda_oe_s, input scl, input sda);
endinterface : smbrp_if

// file: hw/smbrp_sync.sv
// Two-stage synchroniser for one bus line
`timescale 1ns/100ps
module smbrp_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  // Resets high: idle bus level
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : smbrp_sync

// file: hw/smbrp_master.sv
// Bus master: runs send byte, write byte and read byte on command
`timescale 1ns/100ps
`include "smbrp_defines.svh"
module smbrp_master
  import smbrp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  smbrp_if.master         bus,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata
);
  typedef enum logic [2:0] {
    SMBRP_M_IDLE, SMBRP_M_START, SMBRP_M_BIT, SMBRP_M_STOP, SMBRP_M_DONE
  } smbrp_mstate_type;

  // ************************************************
  // Registers and line sampling
  // ************************************************
  smbrp_mstate_type st_q;
  logic [7:0] ptr_q, wd_q, rdv_q, out_q, sh_q, div_q;
  logic [2:0] ctl_q;
  logic [1:0] ph_q, seg_q;
  logic [3:0] bit_q;
  logic       busy_q, nack_q, scl_q, sda_q;
  logic       sda_s, scl_s;
  smbrp_sync u_sda (.clk(clk), .rst(rst), .din(bus.sda), .dout(sda_s));
  smbrp_sync u_scl (.clk(clk), .rst(rst), .din(bus.scl), .dout(scl_s));

  wire tick     = div_q == `SMBRP_HALF_DIV;
  wire go       = wr && addr == `SMBRP_HOST_CMD && wdata[`SMBRP_HOST_START] && !busy_q;
  wire is_read  = ctl_q[`SMBRP_HOST_READ];
  wire rd_phase = is_read && seg_q == 2'd3;
  wire last_seg = is_read ? seg_q == 2'd3 : (ctl_q[`SMBRP_HOST_TWO] ? seg_q == 2'd2 : seg_q == 2'd1);
  // Read: write address, pointer, restart, read address, data byte
  wire [7:0] seg_byte = seg_q == 2'd0 ? {`SMBRP_DEV_ADDR, 1'b0} :
                        (seg_q == 2'd1 ? ptr_q : (is_read ? {`SMBRP_DEV_ADDR, 1'b1} : wd_q));

  // Host register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= 8'h00;
      wd_q  <= 8'h00;
      ctl_q <= 3'b000;
    end else if (wr) begin
      if (addr == `SMBRP_HOST_PTR) ptr_q <= wdata;
      if (addr == `SMBRP_HOST_WDATA) wd_q <= wdata;
      if (go) ctl_q <= wdata[2:0];
    end
  end

  // Quarter-bit divider
  always_ff @(posedge clk) begin
    if (rst || tick || st_q == SMBRP_M_IDLE) div_q <= 8'd0;
    else div_q <= div_q + 8'd1;
  end

  // ************************************************
  // Sequencer: four phases per bit, clock high in 2..3
  // ************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= SMBRP_M_IDLE; ph_q <= 2'd0; seg_q <= 2'd0; bit_q <= 4'd0;
      sh_q <= 8'h00; rdv_q <= 8'h00; nack_q <= 1'b0; busy_q <= 1'b0;
      scl_q <= 1'b1; sda_q <= 1'b1;
    end else begin
      case (st_q)
        SMBRP_M_IDLE: if (go) begin
          st_q <= SMBRP_M_START; busy_q <= 1'b1; nack_q <= 1'b0; seg_q <= 2'd0; ph_q <= 2'd0;
        end
        SMBRP_M_START: if (tick) begin
          ph_q <= ph_q + 2'd1;
          if (ph_q == 2'd0) begin scl_q <= 1'b1; sda_q <= 1'b1; end
          if (ph_q == 2'd1) sda_q <= 1'b0;                             // start or repeated start
          if (ph_q == 2'd2) begin
            scl_q <= 1'b0; st_q <= SMBRP_M_BIT; bit_q <= 4'd0; ph_q <= 2'd0; sh_q <= seg_byte;
          end
        end
        SMBRP_M_BIT: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_q <= bit_q == 4'd8 ? (rd_phase ? 1'b1 : 1'b1) : (rd_phase ? 1'b1 : sh_q[7]);
            2'd1: scl_q <= 1'b1;
            2'd2: begin
              if (bit_q == 4'd8 && !rd_phase) nack_q <= nack_q | sda_s;
              if (bit_q < 4'd8) begin rdv_q <= {rdv_q[6:0], sda_s}; sh_q <= {sh_q[6:0], 1'b0}; end
            end
            default: begin
              scl_q <= 1'b0;
              bit_q <= bit_q + 4'd1;
              if (bit_q == 4'd7) sda_q <= 1'b1;                        // Hand the line over for the acknowledge
              if (bit_q == 4'd8) begin
                bit_q <= 4'd0; seg_q <= seg_q + 2'd1;
                if (last_seg || nack_q) st_q <= SMBRP_M_STOP;
                else if (is_read && seg_q == 2'd1) st_q <= SMBRP_M_START;
                else sh_q <= seg_q == 2'd0 ? ptr_q : wd_q;
              end
            end
          endcase
        end
        SMBRP_M_STOP: if (tick) begin
          ph_q <= ph_q + 2'd1;
          if (ph_q == 2'd0) sda_q <= 1'b0;
          if (ph_q == 2'd1) scl_q <= 1'b1;
          if (ph_q == 2'd2) begin sda_q <= 1'b1; st_q <= SMBRP_M_DONE; end
        end
        SMBRP_M_DONE: begin st_q <= SMBRP_M_IDLE; busy_q <= 1'b0; end
        default: st_q <= SMBRP_M_IDLE;
      endcase
    end
  end

  // Host read data, valid the cycle after the strobe
  wire [7:0] rd_mux = addr == `SMBRP_HOST_STATUS ? {6'h00, nack_q, busy_q} :
                      addr == `SMBRP_HOST_RDATA  ? rdv_q :
                      addr == `SMBRP_HOST_PTR    ? ptr_q :
                      addr == `SMBRP_HOST_WDATA  ? wd_q : 8'h00;
  always_ff @(posedge clk) begin
    if (rst) out_q <= 8'h00;
    else if (rd) out_q <= rd_mux;
  end

  assign rdata        = out_q;
  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = ~scl_q;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = ~sda_q;
endmodule : smbrp_master

// file: verification/smbrp_bus_sva.sv
// Concurrent checks on the two-wire bus between master and register port device
`timescale 1ns/100ps
module smbrp_bus_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_o_m,
  input wire logic scl_oe_m,
  input wire logic sda_o_m,
  input wire logic sda_oe_m,
  input wire logic sda_o_s,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  // ****************************************
  // Bus line checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [10:0] drv_q;
  logic [10:0] drv_d;

  // Length of the current device pull on the data line
  assign drv_d = sda_oe_s ? drv_q + 11'h001 : 11'h000;
  always_ff @(posedge clk) begin
    if (rst)
      drv_q <= 11'h000;
    else
      drv_q <= drv_d;
  end

  a_dev_open_drain: assert property (sda_oe_s |-> !sda_o_s)
    else $error("device drives data line high");
  a_mst_open_drain: assert property ((sda_oe_m |-> !sda_o_m) and (scl_oe_m |-> !scl_o_m))
    else $error("master drives a line high");
  a_dev_change_low: assert property ($changed(sda_oe_s) |-> !scl)
    else $error("device moved data line while clock high");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_one_driver: assert property (!(sda_oe_s && sda_oe_m))
    else $error("both ends pull data line at once");
  a_drive_bounded: assert property (drv_q < 11'd1300)
    else $error("device holds data line too long");
  a_quiet_after_stop: assert property ($rose(sda) && scl |-> !sda_oe_s [*8])
    else $error("device drives data line after stop");
  a_dev_not_early: assert property ($rose(sda_oe_s) |-> !scl [*4])
    else $error("device pull starts near clock rise");
endmodule : smbrp_bus_sva

// file: verification/tb.sv
// Self-checking bench joining master and register port device over the bus
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  $display("[ERR] %0t got %h exp %h", $time, a, b); n_mismatch++; end end
module tb
  import smbrp_pkg::*;
;
  typedef struct packed {logic [7:0] p; logic [7:0] d;} smbrp_tb_row_type;
  logic               clk;
  logic               rst;
  logic [3:0]         addr;
  logic [7:0]         wdata;
  logic               wr;
  logic               rd;
  logic [7:0]         rdata;
  logic [7:0]         v;
  smbrp_pin_role_type pin_role;
  logic [7:0]         pointer;
  logic               timeout_disable;
  int                 n_mismatch;
  int                 check_count;
  smbrp_tb_row_type   rows [0:6];

  smbrp_if bus_if();
  smbrp_device #(.TIMEOUT_CYC(2000)) i_smbrp_device (.clk(clk), .rst(rst), .bus(bus_if), .pin_role(pin_role),
    .pointer(pointer), .timeout_disable(timeout_disable));
  smbrp_master i_smbrp_master (.clk(clk), .rst(rst), .bus(bus_if), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  smbrp_bus_sva i_smbrp_bus_sva (.clk(clk), .rst(rst), .scl_o_m(bus_if.scl_o_m), .scl_oe_m(bus_if.scl_oe_m),
    .sda_o_m(bus_if.sda_o_m), .sda_oe_m(bus_if.sda_oe_m), .sda_o_s(bus_if.sda_o_s),
    .sda_oe_s(bus_if.sda_oe_s), .scl(bus_if.scl), .sda(bus_if.sda));

  // ****************************************
  // Clock and host port tasks
  // ****************************************
  always #4 clk = ~clk;

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // One-cycle host write, then a quiet cycle
  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : hw

  // One-cycle host read, data taken in the following cycle
  task automatic hr(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask : hr

  // Poll busy under a bound, then confirm the device answered
  task automatic wait_idle;
    logic [7:0] s;
    for (int n = 0; n <= 20000; n++) begin
      hr(4'h1, s);
      if (s[0] === 1'b0)
        break;
      if (n == 20000) begin
        n_mismatch++;
        end_of_test();
      end
    end
    `CHK(s[1], 1'b0)
  endtask : wait_idle

  // Load pointer and data, start one transfer and wait for it
  task automatic run(input logic [2:0] c, input logic [7:0] p, input logic [7:0] d);
    hw(4'h2, p);
    hw(4'h3, d);
    hw(4'h0, {5'h00, c});
    wait_idle();
  endtask : run

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    rows = '{'{8'h7d, 8'h00}, '{8'h7d, 8'h01}, '{8'h7d, 8'h02}, '{8'h7d, 8'h03},
             '{8'h40, 8'h40}, '{8'h40, 8'h00}, '{8'h10, 8'ha5}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(pointer, 8'h00)
    `CHK(pin_role, 2'b00)
    // Write byte then read byte back through a repeated start
    for (int i = 0; i < 7; i++) begin
      run(3'b101, rows[i].p, rows[i].d);
      `CHK(pointer, rows[i].p)
      run(3'b011, rows[i].p, 8'h00);
      hr(4'h4, v);
      `CHK(v, rows[i].d)
      if (rows[i].p == 8'h7d) `CHK(pin_role, rows[i].d[1:0])
      if (rows[i].p == 8'h40) `CHK(timeout_disable, rows[i].d[6])
    end
    // Send byte moves the pointer and writes nothing
    run(3'b001, 8'h7d, 8'h00);
    `CHK(pointer, 8'h7d)
    `CHK(pin_role, 2'b11)
    // Pointer survives a long idle bus, longer than the timeout
    repeat (3000) @(posedge clk);
    `CHK(pointer, 8'h7d)
    // A second start while busy is refused
    hw(4'h2, 8'h40);
    hw(4'h3, 8'h40);
    hw(4'h0, 8'h01);
    hw(4'h0, 8'h05);
    wait_idle();
    `CHK(pointer, 8'h40)
    `CHK(timeout_disable, 1'b0)
    // Reset in mid transfer clears state and frees the data line
    hw(4'h0, 8'h05);
    repeat (200) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(pointer, 8'h00)
    `CHK(bus_if.sda, 1'b1)
    end_of_test();
  end
endmodule : tb
